// ### lin_pkg.sv
// Package of constants and types for the single-wire bus transceiver control.
package lin_pkg;
   // ==========================================
   // Timing.
   localparam int clk_mhz = 200;
   localparam int wake_filter_us = 150;
   localparam int wake_filter_cycles = wake_filter_us * clk_mhz + 1;
   localparam int mode_entry_ms = 1;
   localparam int mode_entry_cycles = mode_entry_ms * 1000 * clk_mhz;
   localparam int fifo_width = 1;
   localparam int fifo_depth = 16;
   // ==========================================
   // Reset values.
   localparam logic pullup_cfg_reset = 1'h1;
   localparam logic sleep_cfg_reset = 1'h0;
   // ==========================================
   // Modes.
   typedef enum logic [2:0] {
      mode_normal = 3'h1,
      mode_standby = 3'h2,
      mode_sleep = 3'h4
   } mode_t;
   // ==========================================
   // Pin groups.
   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_t;
endpackage

// ### lin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/10ps
module lin_sync #(
   parameter int width = 1,
   parameter logic [width-1:0] idle = '0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Data.
   input wire logic [width-1:0] d,
   output logic [width-1:0] q
);
   logic [width-1:0] meta_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= idle;
         q <= idle;
      end else if (ce) begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// ### lin_fifo.sv
// Parameterised valid/ready FIFO.
`timescale 1ns/10ps
module lin_fifo #(
   parameter int width = 1,
   parameter int depth = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [width-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [width-1:0] out_data
);
   localparam int aw = $clog2(depth);
   logic [width-1:0] mem [depth];
   logic [aw:0] wr_reg;
   logic [aw:0] rd_reg;
   wire full = (wr_reg[aw] != rd_reg[aw]) && (wr_reg[aw-1:0] == rd_reg[aw-1:0]);
   wire empty = wr_reg == rd_reg;
   wire do_wr = in_valid && !full && ce;
   wire do_rd = out_ready && !empty && ce;
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_reg[aw-1:0]];
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_reg[aw-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (do_wr) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end
endmodule

// ### lin_transceiver_control.sv
// Digital control of a single-wire bus transceiver.
// ==========================================
// Summary of operation
// [RL1] Transmit low pulls bus dominant, high releases.
// [RL2] Driver only pulls low, never drives high.
// [RL3] Receive output follows bus level.
// [RL4] Pull-up setting sampled only in Standby.
// [RL5] Pull-up on in normal, off in Sleep.
// [RL6] Wake on rising edge after dominant over 150us.
// [RL7] Master holds wake dominant over 250us.
// [RL8] Any fault pulls enable pin low.
// [RL9] Host pulses enable pin high before transmit.
// [RL10] Fault-free pulse latches enable pin high weakly.
// [RL11] Host pin switches between output and input. The code holds fault_transmit_enable_oe high, so the pin is always an output.
// [RL12] Standby or Sleep after enable low 1ms.
// [RL13] Wake filter restarts when bus goes recessive.
// [RL14] Driver recessive in low-power or unlatched enable.
`timescale 1ns/10ps
module lin_transceiver_control #(
   parameter int wake_cycles = lin_pkg::wake_filter_cycles,
   parameter int entry_cycles = lin_pkg::mode_entry_cycles
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Host pins.
   input wire logic tx_in,
   output logic rx_out,
   input wire logic chip_enable,
   // Fault/transmit enable pin.
   input wire logic fault_transmit_enable_in,
   output logic fault_transmit_enable_out,
   output logic fault_transmit_enable_oe,
   // Bus pin.
   input wire logic bus_in,
   output logic bus_out,
   output logic bus_oe,
   output logic bus_pullup_enable,
   // Configuration and status.
   input wire logic cfg_pullup,
   input wire logic cfg_sleep,
   input wire logic fault,
   output logic [2:0] mode,
   output logic wake_pulse
);
   // ==========================================
   // Input synchronisers.
   logic [4:0] sync_q;
   // Each stage resets to its pin's idle level, so no false edge follows reset.
   lin_sync #(.width(5), .idle(5'h12)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .ce(clk_en),
      .d({tx_in, chip_enable, fault_transmit_enable_in, bus_in, fault}),
      .q(sync_q)
   );
   wire tx_s = sync_q[4];
   wire ce_s = sync_q[3];
   wire fte_s = sync_q[2];
   wire bus_s = sync_q[1];
   wire fault_s = sync_q[0];
   // ==========================================
   // Transmit buffer.
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [0:0] fifo_out_data;
   lin_fifo #(.width(lin_pkg::fifo_width), .depth(lin_pkg::fifo_depth)) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .ce(clk_en),
      .in_valid(1'b1),
      .in_ready(fifo_in_ready),
      .in_data(tx_s),
      .out_valid(fifo_out_valid),
      .out_ready(1'b1),
      .out_data(fifo_out_data)
   );
   wire tx_buf = fifo_out_valid ? fifo_out_data[0] : 1'b1;
   // ==========================================
   // State.
   lin_pkg::mode_t mode_reg;
   lin_pkg::mode_t mode_next;
   logic [31:0] entry_cnt_reg;
   logic [31:0] wake_cnt_reg;
   logic wake_armed_reg;
   logic pullup_cfg_reg;
   logic txe_latch_reg;
   logic fte_prev_reg;
   logic bus_prev_reg;
   wire is_normal = mode_reg == lin_pkg::mode_normal;
   wire is_standby = mode_reg == lin_pkg::mode_standby;
   wire is_sleep = mode_reg == lin_pkg::mode_sleep;
   wire entry_done = entry_cnt_reg >= 32'(entry_cycles - 1); // RL12
   wire bus_rise = bus_s && !bus_prev_reg;
   wire wake_now = is_sleep && bus_rise && wake_armed_reg; // RL6
   wire fte_rise = fte_s && !fte_prev_reg;
   // ==========================================
   // Mode selection.
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         lin_pkg::mode_normal: begin
            if (!ce_s && entry_done) begin
               mode_next = cfg_sleep ? lin_pkg::mode_sleep : lin_pkg::mode_standby; // RL12
            end
         end
         lin_pkg::mode_standby: begin
            if (ce_s) begin
               mode_next = lin_pkg::mode_normal;
            end
         end
         lin_pkg::mode_sleep: begin
            if (wake_now) begin
               mode_next = ce_s ? lin_pkg::mode_normal : lin_pkg::mode_standby;
            end
         end
         default: begin
            mode_next = lin_pkg::mode_normal;
         end
      endcase
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_reg <= lin_pkg::mode_normal;
         entry_cnt_reg <= '0;
      end else if (clk_en) begin
         mode_reg <= mode_next;
         if (ce_s || !is_normal) begin
            entry_cnt_reg <= '0;
         end else if (!entry_done) begin
            entry_cnt_reg <= entry_cnt_reg + 32'h1;
         end
      end
   end
   // ==========================================
   // Wake filter.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wake_cnt_reg <= '0;
         wake_armed_reg <= 1'b0;
         bus_prev_reg <= 1'b1;
      end else if (clk_en) begin
         bus_prev_reg <= bus_s;
         if (bus_s || !is_sleep) begin
            wake_cnt_reg <= '0; // RL13
         end else if (wake_cnt_reg < 32'(wake_cycles)) begin
            wake_cnt_reg <= wake_cnt_reg + 32'h1;
         end
         wake_armed_reg <= !bus_s && is_sleep && (wake_cnt_reg >= 32'(wake_cycles - 1)); // RL6
      end
   end
   // ==========================================
   // Pull-up configuration and transmit enable latch.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pullup_cfg_reg <= lin_pkg::pullup_cfg_reset;
         txe_latch_reg <= 1'b0;
         fte_prev_reg <= 1'b0;
      end else if (clk_en) begin
         fte_prev_reg <= fte_s;
         if (is_standby) begin
            pullup_cfg_reg <= cfg_pullup; // RL4
         end
         if (fault_s || !is_normal) begin
            txe_latch_reg <= 1'b0; // RL8
         end else if (fte_rise) begin
            txe_latch_reg <= 1'b1; // RL10
         end
      end
   end
   // ==========================================
   // Registered outputs.
   wire drive_low = is_normal && txe_latch_reg && !tx_buf; // RL1 RL14
   wire pullup_next = is_normal ? 1'b1 : (is_sleep ? 1'b0 : pullup_cfg_reg); // RL5
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_out <= 1'b0;
         bus_oe <= 1'b0;
         rx_out <= 1'b1;
         bus_pullup_enable <= 1'b1;
         fault_transmit_enable_out <= 1'b0;
         fault_transmit_enable_oe <= 1'b1;
         mode <= 3'h1;
         wake_pulse <= 1'b0;
      end else if (clk_en) begin
         bus_out <= 1'b0; // RL2
         bus_oe <= drive_low; // RL1
         rx_out <= bus_s; // RL3
         bus_pullup_enable <= pullup_next;
         fault_transmit_enable_out <= txe_latch_reg && !fault_s; // RL8 RL10
         fault_transmit_enable_oe <= 1'b1;
         mode <= mode_reg;
         wake_pulse <= wake_now;
      end
   end
endmodule

// ### lin_partner.sv
// Bus master and host pin model facing the transceiver control.
`timescale 1ns/10ps
module lin_partner (
   // Device side.
   input wire logic bus_out,
   input wire logic bus_oe,
   input wire logic fault_transmit_enable_out,
   input wire logic fault_transmit_enable_oe,
   // Master and host side.
   input wire logic master_low,
   input wire logic host_oe,
   input wire logic host_val,
   // Resolved wires.
   output logic bus_level,
   output logic fte_level
);
   // ==========================================
   // Wire resolution.
   // The master's pull-up keeps the line recessive unless someone pulls it low.
   assign bus_level = !((bus_oe && !bus_out) || master_low);
   // The host's strong drive overrides the weak device drive.
   assign fte_level = host_oe ? host_val : fault_transmit_enable_out;
endmodule

// ### lin_chk.sv
// Port checker for the transceiver control.
`timescale 1ns/10ps
module lin_chk #(
   parameter int wake_cycles = 20,
   parameter int entry_cycles = 50
) (
   // Watched ports.
   input wire logic clk,
   input wire logic nrst,
   input wire logic tx_in,
   input wire logic rx_out,
   input wire logic chip_enable,
   input wire logic fault_transmit_enable_out,
   input wire logic bus_in,
   input wire logic bus_out,
   input wire logic bus_oe,
   input wire logic bus_pullup_enable,
   input wire logic cfg_sleep,
   input wire logic fault,
   input wire logic [2:0] mode,
   input wire logic wake_pulse
);
   logic [7:0] low_reg, run_reg, tx_reg;
   logic [15:0] ce_reg;
   wire in_norm = mode == lin_pkg::mode_normal;
   wire tx_ok = in_norm && fault_transmit_enable_out;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ==========================================
   // Run-length counters.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_reg <= 8'h00;
         run_reg <= 8'h00;
         tx_reg <= 8'h00;
         ce_reg <= 16'h0000;
      end else begin
         low_reg <= bus_in ? 8'h00 : low_reg + {7'h00, low_reg != 8'hff};
         run_reg <= (bus_in && low_reg != 8'h00) ? low_reg : run_reg;
         tx_reg <= ($stable(tx_in) && tx_ok) ? tx_reg + {7'h00, tx_reg != 8'hff} : 8'h00;
         ce_reg <= chip_enable ? 16'h0000 : ce_reg + 16'h0001;
      end
   end
   // ==========================================
   // Assertions.
   a_bus_only_pulls: assert property (bus_oe |-> !bus_out)
      else $error("bus driven high");
   a_tx_drives_bus: assert property (tx_reg == 8'h20 |-> bus_oe == !tx_in)
      else $error("bus not following tx");
   a_rx_follows_bus: assert property ($stable(bus_in) [*4] |-> rx_out == bus_in)
      else $error("rx not following bus");
   a_pullup_normal: assert property (in_norm [*2] |-> bus_pullup_enable)
      else $error("pull-up off in normal");
   a_wake_filter: assert property (wake_pulse |-> run_reg >= wake_cycles)
      else $error("wake on short pulse");
   a_fault_clears: assert property (fault [*4] |-> !fault_transmit_enable_out)
      else $error("enable high under fault");
   a_gate_idle: assert property (!tx_ok [*4] |-> !bus_oe)
      else $error("bus pulled while gated");
   a_mode_entry: assert property ($past(in_norm) && !in_norm |-> ce_reg >= entry_cycles &&
      mode == (cfg_sleep ? lin_pkg::mode_sleep : lin_pkg::mode_standby))
      else $error("bad mode entry");
endmodule
bind lin_transceiver_control lin_chk #(.wake_cycles(wake_cycles), .entry_cycles(entry_cycles))
   u_chk (.*);

// ### tb.sv
// Self-checking bench for the transceiver control.
`timescale 1ns/10ps
module tb;
   logic clk = 1'h0, nrst = 1'h0, tx_in = 1'h1, chip_enable = 1'h1, fault = 1'h0;
   logic cfg_pullup = 1'h1, cfg_sleep = 1'h0, master_low = 1'h0, host_oe = 1'h0;
   logic host_val = 1'h0, wt = 1'h0;
   logic rx_out, fault_transmit_enable_out, fault_transmit_enable_oe, fte_level;
   logic bus_out, bus_oe, bus_level, bus_pullup_enable, wake_pulse;
   logic [2:0] mode;
   logic [15:0] notes[$];
   logic [31:0] lfsr = 32'h444bb311;
   int fails = 0, checks_done = 0;
   event look;
   wire [7:0] obs = {bus_oe, bus_pullup_enable, fault_transmit_enable_out, rx_out, wt, mode};
   always #2.5 clk = !clk;
   always @(posedge clk) if (wake_pulse === 1'h1) wt <= !wt;
   lin_transceiver_control #(.wake_cycles(20), .entry_cycles(50)) u_dut (.clk_en(1'h1),
      .fault_transmit_enable_in(fte_level), .bus_in(bus_level), .*);
   lin_partner u_net (.*);
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic note(input logic [7:0] m, input logic [7:0] e);
      @(negedge clk);
      notes.push_back({m, e});
      -> look;
      @(posedge clk);
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks_done++;
      if (seen !== want) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, seen, want);
      end
   endtask
   task automatic pulse_fte();
      host_oe <= 1'h1;
      host_val <= 1'h1;
      cyc(4);
      host_oe <= 1'h0;
      cyc(6);
   endtask
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========================================
   // Monitor and watchdog.
   always @(look) begin
      logic [15:0] n;
      n = notes.pop_front();
      check(obs & n[15:8], n[7:0]);
      check({6'h00, bus_out, fault_transmit_enable_oe}, 8'h01);
   end
   initial begin
      #100000;
      fails++;
      give_verdict();
   end
   // ==========================================
   // Scenarios.
   initial begin
      cyc(5);
      nrst <= 1'h1;
      cyc(10);
      note(8'hff, {5'h0a, lin_pkg::mode_normal});
      tx_in <= 1'h0;
      cyc(40);
      note(8'h80, 8'h00);
      tx_in <= 1'h1;
      cyc(40);
      pulse_fte();
      note(8'h20, 8'h20);
      for (int i = 0; i < 8; i++) begin
         lfsr = step(lfsr);
         tx_in <= lfsr[0];
         cyc(40);
         note(8'h90, {!lfsr[0], 2'h0, lfsr[0], 4'h0});
      end
      tx_in <= 1'h1;
      fault <= 1'h1;
      cyc(40);
      note(8'h20, 8'h00);
      pulse_fte();
      note(8'h20, 8'h00);
      fault <= 1'h0;
      cyc(5);
      pulse_fte();
      cyc(20);
      note(8'h20, 8'h20);
      cfg_pullup <= 1'h0;
      chip_enable <= 1'h0;
      cyc(30);
      chip_enable <= 1'h1;
      cyc(10);
      note(8'h47, {5'h08, lin_pkg::mode_normal});
      chip_enable <= 1'h0;
      cyc(60);
      note(8'h47, {5'h00, lin_pkg::mode_standby});
      cfg_pullup <= 1'h1;
      cyc(10);
      note(8'h47, {5'h08, lin_pkg::mode_standby});
      cfg_sleep <= 1'h1;
      chip_enable <= 1'h1;
      cyc(10);
      chip_enable <= 1'h0;
      cyc(60);
      note(8'h47, {5'h00, lin_pkg::mode_sleep});
      master_low <= 1'h1;
      cyc(19);
      master_low <= 1'h0;
      cyc(10);
      note(8'h0f, {5'h00, lin_pkg::mode_sleep});
      for (int i = 0; i < 2; i++) begin
         master_low <= 1'h1;
         cyc(12);
         master_low <= 1'h0;
         cyc(2);
      end
      cyc(10);
      note(8'h0f, {5'h00, lin_pkg::mode_sleep});
      master_low <= 1'h1;
      cyc(40);
      master_low <= 1'h0;
      cyc(10);
      note(8'h0f, {5'h01, lin_pkg::mode_standby});
      give_verdict();
   end
endmodule
